// >>> ind_sense_pkg.sv
package ind_sense_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_HIGH_LIMIT_LOWER = 8'h06;
   localparam logic [7:0] OFS_HIGH_LIMIT_UPPER = 8'h07;
   localparam logic [7:0] OFS_LOW_LIMIT_LOWER  = 8'h08;
   localparam logic [7:0] OFS_LOW_LIMIT_UPPER  = 8'h09;
   localparam logic [7:0] OFS_IRQ_PIN_FUNCTION = 8'h0A;
   localparam logic [7:0] OFS_POWER_CONTROL    = 8'h0B;
   localparam logic [7:0] OFS_STATUS_FLAGS     = 8'h20;
   localparam logic [7:0] OFS_PROX_RESULT_LOW  = 8'h21;
   localparam logic [7:0] OFS_PROX_RESULT_HIGH = 8'h22;
   localparam logic [7:0] OFS_FREQ_COUNT_LOW   = 8'h23;
   localparam logic [7:0] OFS_FREQ_COUNT_MID   = 8'h24;
   localparam logic [7:0] OFS_FREQ_COUNT_HIGH  = 8'h25;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_HIGH_LIMIT   = 16'hFFFF;
   localparam logic [15:0] RST_LOW_LIMIT    = 16'h0000;
   localparam logic [7:0]  RST_BYTE_ZERO    = 8'h00;
   localparam logic [7:0]  RST_IRQ_FUNCTION = 8'h00;
   localparam logic [7:0]  RST_POWER        = 8'h00;
   localparam logic [15:0] RST_PROX         = 16'h0000;
   localparam logic [23:0] RST_FREQ         = 24'h000000;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned IRQ_MODE_MSB      = 2;
   localparam int unsigned POWER_ACTIVE_BIT  = 0;
   localparam int unsigned STAT_OSC_BIT      = 7;
   localparam int unsigned STAT_READY_BIT    = 6;
   localparam int unsigned STAT_WAKE_BIT     = 5;
   localparam int unsigned STAT_CMP_BIT      = 4;

   // ---------------------------------------------------------------
   // interrupt pin functions
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      IRQ_DISABLED   = 3'b000,
      IRQ_WAKE_UP    = 3'b001,
      IRQ_COMPARATOR = 3'b010,
      IRQ_DATA_READY = 3'b100
   } irq_mode_t;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] prox;
      logic [23:0] freq;
   } conv_result_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

endpackage

// >>> inductive_sensor_result_regs.sv
module inductive_sensor_result_regs
   import ind_sense_pkg::*;
(
   input  wire logic         ref_clk_i,
   input  wire logic         resetn_i,
   input  wire reg_req_t     reg_req_i,
   output logic       [7:0]  reg_rdata_o,
   input  wire logic         conv_done_i,
   input  wire conv_result_t conv_result_i,
   input  wire logic         osc_fault_i,
   output logic              power_state_select_o,
   output logic       [15:0] high_limit_o,
   output logic       [15:0] low_limit_o,
   output logic              result_ready_out_n_o,
   output logic              irq_out_pin_n_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0]   high_lower_buf_q;
   logic [7:0]   high_lower_buf_d;
   logic [15:0]  high_limit_q;
   logic [15:0]  high_limit_d;
   logic [7:0]   low_lower_buf_q;
   logic [7:0]   low_lower_buf_d;
   logic [15:0]  low_limit_q;
   logic [15:0]  low_limit_d;
   irq_mode_t    irq_mode_q;
   irq_mode_t    irq_mode_d;
   logic         power_active_q;
   logic         power_active_d;
   conv_result_t latest_q;
   conv_result_t latest_d;
   conv_result_t shown_q;
   conv_result_t shown_d;
   logic         ready_q;
   logic         ready_d;
   logic         cmp_q;
   logic         cmp_d;
   logic         wake_trig_q;
   logic         wake_trig_d;
   logic         osc_fault_q;
   logic         osc_fault_d;
   logic [7:0]   rdata_q;
   logic [7:0]   rdata_d;

   logic         conv_take;
   logic         result_load;
   logic [7:0]   status_byte;
   logic         above_high;
   logic         below_low;

   // ---------------------------------------------------------------
   // access decode
   // ---------------------------------------------------------------
   // conversions arriving in standby are dropped, the engine is idle
   assign conv_take   = conv_done_i & power_active_q;
   assign result_load = reg_req_i.rd
                        & (reg_req_i.addr == OFS_PROX_RESULT_LOW);
   // one compare pair feeds both flags; the wake flag uses only above_high, and only in wake-up mode
   assign above_high  = latest_q.prox > high_limit_q;
   assign below_low   = latest_q.prox < low_limit_q;

   // ---------------------------------------------------------------
   // limit registers
   // ---------------------------------------------------------------
   always_comb
   begin
      high_lower_buf_d = high_lower_buf_q;
      high_limit_d     = high_limit_q;
      low_lower_buf_d  = low_lower_buf_q;
      low_limit_d      = low_limit_q;
      if (reg_req_i.wr)
      begin
         case (reg_req_i.addr)
            OFS_HIGH_LIMIT_LOWER:
            begin
               high_lower_buf_d = reg_req_i.wdata;
            end
            OFS_HIGH_LIMIT_UPPER:
            begin
               high_limit_d = {reg_req_i.wdata, high_lower_buf_q};
            end
            OFS_LOW_LIMIT_LOWER:
            begin
               low_lower_buf_d = reg_req_i.wdata;
            end
            OFS_LOW_LIMIT_UPPER:
            begin
               low_limit_d = {reg_req_i.wdata, low_lower_buf_q};
            end
            default:
            begin
               high_limit_d = high_limit_q;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         high_lower_buf_q <= RST_HIGH_LIMIT[7:0];
         high_limit_q     <= RST_HIGH_LIMIT;
         low_lower_buf_q  <= RST_LOW_LIMIT[7:0];
         low_limit_q      <= RST_LOW_LIMIT;
      end
      else
      begin
         high_lower_buf_q <= high_lower_buf_d;
         high_limit_q     <= high_limit_d;
         low_lower_buf_q  <= low_lower_buf_d;
         low_limit_q      <= low_limit_d;
      end
   end

   // ---------------------------------------------------------------
   // pin function and power control
   // ---------------------------------------------------------------
   always_comb
   begin
      irq_mode_d     = irq_mode_q;
      power_active_d = power_active_q;
      if (reg_req_i.wr && (reg_req_i.addr == OFS_IRQ_PIN_FUNCTION))
      begin
         // reserved upper bits are not stored
         irq_mode_d = irq_mode_t'(reg_req_i.wdata[IRQ_MODE_MSB:0]);
      end
      if (reg_req_i.wr && (reg_req_i.addr == OFS_POWER_CONTROL))
      begin
         power_active_d = reg_req_i.wdata[POWER_ACTIVE_BIT];
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         irq_mode_q     <= irq_mode_t'(RST_IRQ_FUNCTION[IRQ_MODE_MSB:0]);
         power_active_q <= RST_POWER[POWER_ACTIVE_BIT];
      end
      else
      begin
         irq_mode_q     <= irq_mode_d;
         power_active_q <= power_active_d;
      end
   end

   // ---------------------------------------------------------------
   // conversion capture and result snapshot
   // ---------------------------------------------------------------
   always_comb
   begin
      latest_d = latest_q;
      shown_d  = shown_q;
      ready_d  = ready_q;
      if (conv_take)
      begin
         latest_d = conv_result_i;
      end
      if (result_load)
      begin
         // a conversion landing in the same cycle waits for the next read
         shown_d = latest_q;
         ready_d = 1'b0;
      end
      if (conv_take)
      begin
         // set beats clear so a coincident result is still flagged
         ready_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         latest_q <= '{prox: RST_PROX, freq: RST_FREQ};
         shown_q  <= '{prox: RST_PROX, freq: RST_FREQ};
         ready_q  <= 1'b0;
      end
      else
      begin
         latest_q <= latest_d;
         shown_q  <= shown_d;
         ready_q  <= ready_d;
      end
   end

   // ---------------------------------------------------------------
   // comparator, wake-up and oscillator flags
   // ---------------------------------------------------------------
   always_comb
   begin
      cmp_d       = cmp_q;
      wake_trig_d = wake_trig_q;
      osc_fault_d = osc_fault_i;
      // between the limits the comparator holds its last side
      if (above_high)
      begin
         cmp_d = 1'b0;
      end
      else if (below_low)
      begin
         cmp_d = 1'b1;
      end
      if (irq_mode_q != IRQ_WAKE_UP)
      begin
         wake_trig_d = 1'b0;
      end
      else if (above_high)
      begin
         wake_trig_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         cmp_q       <= 1'b1;
         wake_trig_q <= 1'b0;
         osc_fault_q <= 1'b0;
      end
      else
      begin
         cmp_q       <= cmp_d;
         wake_trig_q <= wake_trig_d;
         osc_fault_q <= osc_fault_d;
      end
   end

   // flags are active low; low nibble reads as zero
   // a status read clears no flag, so repeated status reads stay identical
   always_comb
   begin
      status_byte                 = RST_BYTE_ZERO;
      status_byte[STAT_OSC_BIT]   = ~osc_fault_q;
      status_byte[STAT_READY_BIT] = ~ready_q;
      status_byte[STAT_WAKE_BIT]  = ~wake_trig_q;
      status_byte[STAT_CMP_BIT]   = cmp_q;
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   always_comb
   begin
      rdata_d = rdata_q;
      if (reg_req_i.rd)
      begin
         case (reg_req_i.addr)
            OFS_HIGH_LIMIT_LOWER:
            begin
               rdata_d = high_limit_q[7:0];
            end
            OFS_HIGH_LIMIT_UPPER:
            begin
               rdata_d = high_limit_q[15:8];
            end
            OFS_LOW_LIMIT_LOWER:
            begin
               rdata_d = low_limit_q[7:0];
            end
            OFS_LOW_LIMIT_UPPER:
            begin
               rdata_d = low_limit_q[15:8];
            end
            OFS_IRQ_PIN_FUNCTION:
            begin
               rdata_d = {5'h00, irq_mode_q};
            end
            OFS_POWER_CONTROL:
            begin
               rdata_d = {7'h00, power_active_q};
            end
            OFS_STATUS_FLAGS:
            begin
               rdata_d = status_byte;
            end
            // the low byte read returns the freshly loaded value
            OFS_PROX_RESULT_LOW:  rdata_d = latest_q.prox[7:0];
            OFS_PROX_RESULT_HIGH: rdata_d = shown_q.prox[15:8];
            OFS_FREQ_COUNT_LOW:   rdata_d = shown_q.freq[7:0];
            OFS_FREQ_COUNT_MID:   rdata_d = shown_q.freq[15:8];
            OFS_FREQ_COUNT_HIGH:  rdata_d = shown_q.freq[23:16];
            default:              rdata_d = RST_BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!resetn_i)
      begin
         rdata_q <= RST_BYTE_ZERO;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // interrupt pin
   // ---------------------------------------------------------------
   always_comb
   begin
      case (irq_mode_q)
         IRQ_DATA_READY: irq_out_pin_n_o = ~ready_q;
         IRQ_COMPARATOR: irq_out_pin_n_o = cmp_q;
         IRQ_WAKE_UP:    irq_out_pin_n_o = ~wake_trig_q;
         IRQ_DISABLED:   irq_out_pin_n_o = 1'b1;
         // reserved codes leave the pin idle
         default:        irq_out_pin_n_o = 1'b1;
      endcase
   end

   assign reg_rdata_o          = rdata_q;
   assign power_state_select_o = power_active_q;
   assign high_limit_o         = high_limit_q;
   assign low_limit_o          = low_limit_q;
   assign result_ready_out_n_o = ~ready_q;

endmodule // inductive_sensor_result_regs

// >>> isr_checker.sv
// --------------------
// register side checks
// --------------------
module isr_checker
   import ind_sense_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        resetn_i,
   input wire reg_req_t    reg_req_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        conv_done_i,
   input wire logic        power_state_select_o,
   input wire logic [15:0] high_limit_o,
   input wire logic [15:0] low_limit_o,
   input wire logic        result_ready_out_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   wire logic       wr = reg_req_i.wr;
   // a read beside a write could see the limit move
   wire logic       rd = reg_req_i.rd && !reg_req_i.wr;
   wire logic [7:0] a  = reg_req_i.addr;
   wire logic [7:0] d  = reg_req_i.wdata;
   wire logic       rn = result_ready_out_n_o;
   sequence s_lo;
      wr && a == OFS_LOW_LIMIT_LOWER ##1 wr && a == OFS_LOW_LIMIT_UPPER;
   endsequence
   sequence s_hi;
      wr && a == OFS_HIGH_LIMIT_LOWER ##1 wr && a == OFS_HIGH_LIMIT_UPPER;
   endsequence
   property p_lo;
      s_lo |=> low_limit_o == {$past(d), $past(d, 2)};
   endproperty
   a_lo: assert property (p_lo) else $error("low commit");
   property p_hi;
      s_hi |=> high_limit_o == {$past(d), $past(d, 2)};
   endproperty
   a_hi: assert property (p_hi) else $error("high commit");
   property p_rdu;
      rd && a == OFS_LOW_LIMIT_UPPER |=> reg_rdata_o == low_limit_o[15:8];
   endproperty
   a_rdu: assert property (p_rdu) else $error("low upper read");
   property p_rdl;
      rd && a == OFS_LOW_LIMIT_LOWER |=> reg_rdata_o == low_limit_o[7:0];
   endproperty
   a_rdl: assert property (p_rdl) else $error("low lower read");
   property p_pwr;
      wr && a == OFS_POWER_CONTROL |=> power_state_select_o == $past(d[0]);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power bit");
   property p_set;
      conv_done_i && power_state_select_o |=> !rn;
   endproperty
   a_set: assert property (p_set) else $error("ready set");
   property p_clr;
      rd && a == OFS_PROX_RESULT_LOW && !conv_done_i |=> rn;
   endproperty
   a_clr: assert property (p_clr) else $error("ready clear");
   property p_keep;
      rd && a == OFS_STATUS_FLAGS && !rn |=> !rn;
   endproperty
   a_keep: assert property (p_keep) else $error("status read");
endmodule // isr_checker

bind inductive_sensor_result_regs isr_checker u_isr_checker (
   .ref_clk_i            (ref_clk_i),
   .resetn_i             (resetn_i),
   .reg_req_i            (reg_req_i),
   .reg_rdata_o          (reg_rdata_o),
   .conv_done_i          (conv_done_i),
   .power_state_select_o (power_state_select_o),
   .high_limit_o         (high_limit_o),
   .low_limit_o          (low_limit_o),
   .result_ready_out_n_o (result_ready_out_n_o)
);

// >>> host_model.sv
// --------------------
// host on the register port
// --------------------
module host_model
   import ind_sense_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic [7:0] rdata_i,
   output reg_req_t        req_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req_o = '0;
   task automatic put(input logic [7:0] a, d, input logic w, r);
      @(negedge ref_clk_i);
      req_o = '{addr: a, wdata: d, wr: w, rd: r};
   endtask
   // released lines show the inverse, never a stale copy
   task automatic idle();
      put(~req_o.addr, ~req_o.wdata, 1'b0, 1'b0);
   endtask
   task automatic wr_byte(input logic [7:0] a, d);
      put(a, d, 1'b1, 1'b0);
      idle();
   endtask
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
      put(a, ~req_o.wdata, 1'b0, 1'b1);
      idle();
      d = rdata_i;
   endtask
   task automatic wr_pair(input logic [7:0] a, input logic [15:0] v);
      put(a, v[7:0], 1'b1, 1'b0);
      put(a + 8'h01, v[15:8], 1'b1, 1'b0);
      idle();
   endtask
   task automatic set_mode(input irq_mode_t m);
      wr_byte(OFS_IRQ_PIN_FUNCTION, {5'h00, m});
   endtask
   // low byte first: it loads the snapshot the others come from
   task automatic rd_result(output logic [39:0] r);
      rd_byte(OFS_PROX_RESULT_LOW, r[7:0]);
      for (int i = 1; i < 5; i++)
         rd_byte(OFS_PROX_RESULT_LOW + 8'(i), r[8*i +: 8]);
   endtask
endmodule // host_model

// >>> tb_inductive_sensor_result_regs.sv
// --------------------
// testbench
// --------------------
`define CHK(s, e, g) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         n_errors++; \
         $display("mismatch %s exp %h got %h", s, e, g); \
      end \
   end

module tb_inductive_sensor_result_regs
   import ind_sense_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed { logic [7:0] a, d, e; } row_t;
   logic         clk = 1'b0;
   logic         resetn = 1'b0;
   logic         conv_done = 1'b0;
   logic         osc_fault = 1'b0;
   conv_result_t conv_res = '0;
   reg_req_t     req;
   logic [7:0]   rdata, b;
   logic         power, rdy_n, irq_n;
   logic [15:0]  hi_lim, lo_lim;
   logic [39:0]  r;
   int           n_errors = 0;
   int           check_count = 0;
   row_t         rows [6] = '{
      '{OFS_IRQ_PIN_FUNCTION, 8'hFC, 8'h04},
      '{OFS_IRQ_PIN_FUNCTION, 8'h02, 8'h02},
      '{OFS_POWER_CONTROL, 8'hFE, 8'h00},
      '{OFS_POWER_CONTROL, 8'h01, 8'h01},
      '{OFS_PROX_RESULT_HIGH, 8'h55, 8'h00},
      '{8'h30, 8'hAA, 8'h00}
   };
   always #50 clk = ~clk;
   inductive_sensor_result_regs u_inductive_sensor_result_regs (
      .ref_clk_i            (clk),
      .resetn_i             (resetn),
      .reg_req_i            (req),
      .reg_rdata_o          (rdata),
      .conv_done_i          (conv_done),
      .conv_result_i        (conv_res),
      .osc_fault_i          (osc_fault),
      .power_state_select_o (power),
      .high_limit_o         (hi_lim),
      .low_limit_o          (lo_lim),
      .result_ready_out_n_o (rdy_n),
      .irq_out_pin_n_o      (irq_n)
   );
   host_model u_host_model (
      .ref_clk_i (clk),
      .rdata_i   (rdata),
      .req_o     (req)
   );
   task automatic conv(input logic [15:0] p, input logic [23:0] f);
      @(negedge clk);
      conv_done = 1'b1;
      conv_res = '{prox: p, freq: f};
      @(negedge clk);
      conv_done = 1'b0;
      conv_res = ~conv_res;
   endtask
   task automatic rdchk(input string s, input logic [7:0] a, e);
      u_host_model.rd_byte(a, b);
      `CHK(s, e, b)
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // the whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
   initial
   begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      foreach (rows[i])
      begin
         u_host_model.wr_byte(rows[i].a, rows[i].d);
         rdchk("row", rows[i].a, rows[i].e);
      end
      $display("test rows done");
      resetn = 1'b0;
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      `CHK("power", 1'b0, power)
      `CHK("irq", 1'b1, irq_n)
      `CHK("hi_rst", 16'hFFFF, hi_lim)
      `CHK("rdy_rst", 1'b1, rdy_n)
      rdchk("lo_up", OFS_LOW_LIMIT_UPPER, 8'h00);
      rdchk("mode", OFS_IRQ_PIN_FUNCTION, 8'h00);
      $display("test reset done");
      u_host_model.wr_byte(OFS_LOW_LIMIT_LOWER, 8'h34);
      rdchk("lo_buf", OFS_LOW_LIMIT_LOWER, 8'h00);
      u_host_model.wr_byte(OFS_LOW_LIMIT_UPPER, 8'h12);
      `CHK("lo_lim", 16'h1234, lo_lim)
      rdchk("lo_up", OFS_LOW_LIMIT_UPPER, 8'h12);
      rdchk("lo_low", OFS_LOW_LIMIT_LOWER, 8'h34);
      u_host_model.wr_pair(OFS_LOW_LIMIT_LOWER, 16'h2345);
      `CHK("lo_pair", 16'h2345, lo_lim)
      u_host_model.wr_pair(OFS_HIGH_LIMIT_LOWER, 16'h7856);
      `CHK("hi_lim", 16'h7856, hi_lim)
      $display("test limits done");
      conv(16'h9000, 24'h123456);
      `CHK("stby", 1'b1, rdy_n)
      u_host_model.wr_byte(OFS_POWER_CONTROL, 8'h01);
      u_host_model.set_mode(IRQ_DATA_READY);
      conv(16'h9000, 24'h123456);
      `CHK("irq", 1'b0, irq_n)
      rdchk("stat", OFS_STATUS_FLAGS, 8'hA0);
      rdchk("stat", OFS_STATUS_FLAGS, 8'hA0);
      u_host_model.rd_result(r);
      `CHK("res", 40'h1234569000, r)
      `CHK("irq", 1'b1, irq_n)
      conv(16'h0100, 24'h0A0B0C);
      rdchk("p_hi", OFS_PROX_RESULT_HIGH, 8'h90);
      u_host_model.rd_result(r);
      `CHK("res", 40'h0A0B0C0100, r)
      rdchk("stat", OFS_STATUS_FLAGS, 8'hF0);
      $display("test results done");
      u_host_model.set_mode(IRQ_COMPARATOR);
      `CHK("irq", 1'b1, irq_n)
      conv(16'h9000, 24'h000001);
      rdchk("stat", OFS_STATUS_FLAGS, 8'hA0);
      `CHK("irq", 1'b0, irq_n)
      u_host_model.set_mode(IRQ_WAKE_UP);
      conv(16'h9000, 24'h000002);
      rdchk("stat", OFS_STATUS_FLAGS, 8'h80);
      `CHK("irq", 1'b0, irq_n)
      u_host_model.set_mode(IRQ_DISABLED);
      osc_fault = 1'b1;
      `CHK("irq", 1'b1, irq_n)
      rdchk("stat", OFS_STATUS_FLAGS, 8'h20);
      $display("test modes done");
      fork
         conv(16'h4321, 24'h00ABCD);
         u_host_model.rd_byte(OFS_PROX_RESULT_LOW, b);
      join
      `CHK("set_win", 1'b0, rdy_n)
      `CHK("old_lo", 8'h00, b)
      rdchk("old_hi", OFS_PROX_RESULT_HIGH, 8'h90);
      u_host_model.rd_result(r);
      `CHK("res", 40'h00ABCD4321, r)
      `CHK("rdy_clr", 1'b1, rdy_n)
      $display("test overlap done");
      give_verdict();
   end
endmodule // tb_inductive_sensor_result_regs
